// File: rtl/tocm_defs.svh
// Constants for the trip output command and over-speed test block.
// Assumes a 10 MHz system clock and a word-aligned AHB-Lite register map.
`ifndef TOCM_DEFS_SVH
`define TOCM_DEFS_SVH

// ----------------------------------------------------------------------
// Register word indices; the byte address is four times the index
// ----------------------------------------------------------------------
`define TOCM_OFS_CMD 6'h00
`define TOCM_OFS_STATUS 6'h01
`define TOCM_OFS_IRQ_STAT 6'h02
`define TOCM_OFS_IRQ_MASK 6'h03
`define TOCM_OFS_TIMEOUT 6'h04

// ----------------------------------------------------------------------
// Field positions in the command boolean rack register
// ----------------------------------------------------------------------
`define TOCM_CMD_EN_LSB 0
`define TOCM_CMD_VAL_LSB 6
`define TOCM_CMD_TEST_LSB 12
`define TOCM_CMD_RST_LSB 15
`define TOCM_CMD_WIDTH 30

// ----------------------------------------------------------------------
// Field positions in the status and interrupt registers
// ----------------------------------------------------------------------
`define TOCM_ST_RELAY_LSB 0
`define TOCM_ST_LATCH_LSB 6
`define TOCM_ST_TEST_LSB 12
`define TOCM_ST_LINK_BIT 15
`define TOCM_IRQ_TRIP_LSB 0
`define TOCM_IRQ_CANCEL_LSB 6
`define TOCM_IRQ_LINK_BIT 9
`define TOCM_IRQ_WIDTH 10

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TOCM_CMD_RESET 30'h0000_0000
`define TOCM_MASK_RESET 10'h000
`define TOCM_TIMEOUT_RESET 16'h2710

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TOCM_CLK_NS 100
`define TOCM_MS_NS 1000000

`endif

// File: rtl/tocm_pkg.sv
// Types shared by the trip output command block.
// Assumes the constants header is included by the design files.
package tocm_pkg;

	// AHB-Lite transfer type.
	typedef logic [1:0] tocm_htrans_t;

	// Over-speed test state of one group.
	typedef enum logic [1:0] {
		TOCM_TEST_IDLE,
		TOCM_TEST_ACTIVE,
		TOCM_TEST_HOLD
	} tocm_test_st_t;

endpackage

// File: rtl/tocm_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output settles after stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module tocm_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] d_out
);

	// ------------------------------------------------------------------
	// Per-bit stages
	// ------------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic out_reg;
			// The first stage only feeds the second, so metastability stays put.
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					out_reg <= 1'b0;
				end else begin
					s1_reg <= d_in[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg) begin
						out_reg <= s3_reg;
					end
				end
			end
			assign d_out[i] = out_reg;
		end
	endgenerate

endmodule

`default_nettype wire

// File: rtl/tocm_top.sv
// Trip output command override and over-speed test control, three groups.
// Assumes an AHB-Lite master, monitoring trip inputs on the same clock and
// asynchronous link health pins from the main processor interface.
//
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tocm_defs.svh"

// Summary of operation
// - With command enable set, each output follows its paired command bit.
// - A trip found by the monitoring always beats any commanded output state.
// - Enabled outputs trip when the processor link is lost or application stops.
// - With command enable clear, the output follows monitoring only.
// - Command bit zero with enable set trips the output, relay de-energised.
// - Command bit one leaves normal monitoring of that output unchanged.
// - Test enable one raises the group's over-speed threshold to test level.
// - Test enable zero keeps the normal over-speed threshold in use.
// - One shared timeout ends each group's over-speed test when it expires.
// - Test cancels on enable low, over-speed trip, timeout, or zero speed.
// - Each group's test state is readable in the status register.
// - Trip reset rising edge clears a latched trip unless condition persists.
module tocm_top #(
	parameter int MS_CYCLES = `TOCM_MS_NS / `TOCM_CLK_NS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire tocm_pkg::tocm_htrans_t htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Monitoring inputs, same clock
	input wire logic [5:0] mon_trip,
	input wire logic [2:0] zero_speed,
	// Link health pins
	input wire logic comm_lost,
	input wire logic app_stopped,
	// Outputs
	output logic [5:0] relay_energize,
	output logic [2:0] os_test_active,
	output logic irq
);
	import tocm_pkg::*;

	// ------------------------------------------------------------------
	// Link health synchronisation
	// ------------------------------------------------------------------
	logic [1:0] link_pins;
	logic [1:0] link_sync;
	logic link_lost;

	assign link_pins = {app_stopped, comm_lost};
	assign link_lost = |link_sync;

	tocm_sync #(.W(2)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d_in(link_pins),
		.d_out(link_sync)
	);

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	logic [29:0] cmd_reg;
	logic [9:0] irq_stat_reg;
	logic [9:0] irq_mask_reg;
	logic [15:0] timeout_reg;
	logic [5:0] latch_reg;
	logic [5:0] relay_reg;
	logic [2:0] test_act;
	logic link_reg;
	logic wr_pend_reg;
	logic [5:0] wr_idx_reg;
	logic hrdy_reg;
	logic [31:0] hrdata_reg;
	logic addr_ok;
	logic [5:0] a_idx;
	logic rd_take;
	logic wr_take;
	logic [31:0] rd_mux;
	logic wr_cmd;
	logic wr_istat;
	logic wr_imask;
	logic wr_tmo;
	logic [31:0] status_word;

	// Only a live selected transfer is accepted; hsize is not checked.
	assign addr_ok = hsel && hready && htrans[1];
	assign a_idx = haddr[7:2];
	assign rd_take = addr_ok && !hwrite;
	assign wr_take = addr_ok && hwrite;
	assign wr_cmd = wr_pend_reg && (wr_idx_reg == `TOCM_OFS_CMD);
	assign wr_istat = wr_pend_reg && (wr_idx_reg == `TOCM_OFS_IRQ_STAT);
	assign wr_imask = wr_pend_reg && (wr_idx_reg == `TOCM_OFS_IRQ_MASK);
	assign wr_tmo = wr_pend_reg && (wr_idx_reg == `TOCM_OFS_TIMEOUT);

	// Test state is made visible to software here.
	// status test bits
	assign status_word = {16'h0000, link_reg, test_act, latch_reg, relay_reg};

	// Unmapped addresses read as zero and ignore writes.
	assign rd_mux =
		(a_idx == `TOCM_OFS_CMD) ? {2'b00, cmd_reg} :
		(a_idx == `TOCM_OFS_STATUS) ? status_word :
		(a_idx == `TOCM_OFS_IRQ_STAT) ? {22'h000000, irq_stat_reg} :
		(a_idx == `TOCM_OFS_IRQ_MASK) ? {22'h000000, irq_mask_reg} :
		(a_idx == `TOCM_OFS_TIMEOUT) ? {16'h0000, timeout_reg} :
		32'h0000_0000;

	// Zero wait states: read data is registered during the address phase.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hrdy_reg <= 1'b1;
			hrdata_reg <= 32'h0000_0000;
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= 6'h00;
		end else begin
			hrdy_reg <= 1'b1;
			wr_pend_reg <= wr_take;
			if (wr_take) begin
				wr_idx_reg <= a_idx;
			end
			if (rd_take) begin
				hrdata_reg <= rd_mux;
			end
		end
	end

	assign hreadyout = hrdy_reg;
	assign hrdata = hrdata_reg;
	assign hresp = 1'b0;

	// ------------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------------
	logic [9:0] irq_event;
	logic [9:0] irq_stat_next;

	// A new event wins over a write-one-to-clear in the same cycle.
	assign irq_stat_next = (irq_stat_reg & ~(wr_istat ? hwdata[9:0] : 10'h000))
		| irq_event;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmd_reg <= `TOCM_CMD_RESET;
			irq_mask_reg <= `TOCM_MASK_RESET;
			timeout_reg <= `TOCM_TIMEOUT_RESET;
			irq_stat_reg <= 10'h000;
		end else begin
			if (wr_cmd) begin
				cmd_reg <= hwdata[29:0];
			end
			if (wr_imask) begin
				irq_mask_reg <= hwdata[9:0];
			end
			if (wr_tmo) begin
				timeout_reg <= hwdata[15:0];
			end
			irq_stat_reg <= irq_stat_next;
		end
	end

	// ------------------------------------------------------------------
	// Output trip logic
	// ------------------------------------------------------------------
	logic [5:0] rst_prev_reg;
	logic [5:0] trip_now;
	logic [5:0] relay_prev_reg;
	logic link_prev_reg;

	genvar i;
	generate
		for (i = 0; i < 6; i++) begin : g_out
			logic en;
			logic cmd_val;
			logic rst_rise;
			logic forced;
			assign en = cmd_reg[`TOCM_CMD_EN_LSB + i];
			assign cmd_val = cmd_reg[`TOCM_CMD_VAL_LSB + i];
			assign rst_rise = cmd_reg[`TOCM_CMD_RST_LSB + i] && !rst_prev_reg[i];
			assign forced = en && (!cmd_val || link_lost);
			assign trip_now[i] = latch_reg[i] || mon_trip[i] || forced;

			// The latch is set while the condition holds, so a reset cannot
			// clear it until the monitoring trip has gone away.
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					latch_reg[i] <= 1'b0;
				end else if (mon_trip[i]) begin
					latch_reg[i] <= 1'b1;
				end else if (rst_rise) begin
					latch_reg[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// Relays are energised when healthy; a trip de-energises them.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			relay_reg <= 6'h00;
			relay_prev_reg <= 6'h00;
			rst_prev_reg <= 6'h00;
			link_reg <= 1'b0;
			link_prev_reg <= 1'b0;
		end else begin
			relay_reg <= ~trip_now;
			relay_prev_reg <= relay_reg;
			rst_prev_reg <= cmd_reg[`TOCM_CMD_RST_LSB +: 6];
			link_reg <= link_lost;
			link_prev_reg <= link_reg;
		end
	end

	assign relay_energize = relay_reg;

	// ------------------------------------------------------------------
	// Over-speed test control
	// ------------------------------------------------------------------
	logic [13:0] ms_cnt_reg;
	logic ms_tick;
	logic [2:0] cancel_ev;

	// A shared millisecond tick keeps the per-group timers narrow.
	assign ms_tick = (ms_cnt_reg == 14'(MS_CYCLES - 1));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ms_cnt_reg <= 14'h0000;
		end else if (ms_tick) begin
			ms_cnt_reg <= 14'h0000;
		end else begin
			ms_cnt_reg <= ms_cnt_reg + 14'h0001;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_test
			tocm_test_st_t st_reg;
			tocm_test_st_t st_next;
			logic [15:0] tm_reg;
			logic ten;
			logic expired;
			logic auto_cancel;
			logic act_reg;
			assign ten = cmd_reg[`TOCM_CMD_TEST_LSB + g];
			assign expired = (tm_reg >= timeout_reg);
			assign auto_cancel = mon_trip[2 * g] || expired || zero_speed[g];

			always_comb begin
				st_next = st_reg;
				unique case (st_reg)
					TOCM_TEST_IDLE: begin
						if (ten && !auto_cancel) begin
							st_next = TOCM_TEST_ACTIVE;
						end
					end
					TOCM_TEST_ACTIVE: begin
						if (!ten) begin
							st_next = TOCM_TEST_IDLE;
						end else if (auto_cancel) begin
							st_next = TOCM_TEST_HOLD;
						end
					end
					TOCM_TEST_HOLD: begin
						if (!ten) begin
							st_next = TOCM_TEST_IDLE;
						end
					end
				endcase
			end

			// Timer restarts on every entry into the active state.
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					st_reg <= TOCM_TEST_IDLE;
					tm_reg <= 16'h0000;
					act_reg <= 1'b0;
				end else begin
					st_reg <= st_next;
					act_reg <= (st_next == TOCM_TEST_ACTIVE);
					if (st_reg != TOCM_TEST_ACTIVE) begin
						tm_reg <= 16'h0000;
					end else if (ms_tick && !expired) begin
						tm_reg <= tm_reg + 16'h0001;
					end
				end
			end

			assign test_act[g] = act_reg;
			assign cancel_ev[g] = (st_reg == TOCM_TEST_ACTIVE)
				&& (st_next == TOCM_TEST_HOLD);
		end
	endgenerate

	assign os_test_active = test_act;

	// ------------------------------------------------------------------
	// Interrupt events
	// ------------------------------------------------------------------
	logic irq_reg;

	// Trip events fire when a relay drops; link loss fires on its onset.
	assign irq_event = {link_reg && !link_prev_reg, cancel_ev,
		relay_prev_reg & ~relay_reg};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(irq_stat_next & irq_mask_reg);
		end
	end

	assign irq = irq_reg;

endmodule

`default_nettype wire

// File: testbench/tb_tocm_top.sv
// Self-checking bench for the trip output command block.
// Assumes the host model drives the bus and link pins.
`timescale 1ns/1ps
`default_nettype none
`include "tocm_defs.svh"
module tb_tocm_top;
	import tocm_pkg::*;
	logic clk = 1'b0;
	logic rst_n, hsel, hwrite, hreadyout, hresp, irq, rd_phase;
	logic comm_lost, app_stopped;
	logic [31:0] haddr, hwdata, hrdata, r;
	tocm_htrans_t htrans;
	logic [5:0] mon_trip, relay_energize;
	logic [2:0] zero_speed, os_test_active;
	logic [31:0] exp_q[$];
	int num_errors = 0;
	int n_compared = 0;
	int seed = 72713;
	int n;

	always #50 clk = ~clk;

	tocm_host i_tocm_host (.clk(clk), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
		.hready(hreadyout), .rd_phase(rd_phase), .comm_lost(comm_lost),
		.app_stopped(app_stopped));
	// Short millisecond keeps timeouts in tens of cycles.
	tocm_top #(.MS_CYCLES(10)) i_tocm_top (.clk(clk), .rst_n(rst_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.mon_trip(mon_trip), .zero_speed(zero_speed),
		.comm_lost(comm_lost), .app_stopped(app_stopped),
		.relay_energize(relay_energize), .os_test_active(os_test_active),
		.irq(irq));

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wrap_up;
		$display("compared %0d mismatched %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	function automatic logic [31:0] ad(input logic [5:0] i);
		return {24'h0, i, 2'h0};
	endfunction

	task automatic wr(input logic [5:0] i, input logic [31:0] d);
		i_tocm_host.xfer(1'b1, ad(i), d);
	endtask

	// The note goes in before the read, so the watcher always finds it.
	task automatic rd(input logic [5:0] i, input logic [31:0] e);
		exp_q.push_back(e);
		i_tocm_host.xfer(1'b0, ad(i), 32'h0);
	endtask

	// Bounded wait for a test state; n returns the cycles spent.
	task automatic wt(input logic [2:0] e, output int cnt);
		for (cnt = 0; cnt < 200 && os_test_active !== e; cnt++)
			@(posedge clk);
		if (cnt == 200) begin
			chk("os_test_active", 32'(e), 32'(os_test_active));
			wrap_up();
		end
	endtask

	// Read data watcher: oldest note against each data phase.
	always @(posedge clk) begin
		if (rd_phase === 1'b1 && hreadyout === 1'b1) begin
			if (exp_q.size() == 0)
				chk("read note", 32'h0, 32'h1);
			else
				chk("hrdata", exp_q.pop_front(), hrdata);
		end
	end

	// A hang anywhere still ends with a verdict.
	initial begin
		repeat (50000) @(posedge clk);
		chk("watchdog", 32'h0, 32'h1);
		wrap_up();
	end

	initial begin
		rst_n = 1'b0;
		mon_trip = 6'h00;
		zero_speed = 3'h0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		rd(`TOCM_OFS_TIMEOUT, 32'h2710);
		rd(`TOCM_OFS_CMD, 32'h0);
		rd(`TOCM_OFS_IRQ_MASK, 32'h0);
		rd(6'h05, 32'h0);
		rd(`TOCM_OFS_STATUS, 32'h3f);
		$display("test reset done");
		// Commanded states, first pass forces every output to trip.
		for (int k = 0; k < 5; k++) begin
			r = (k == 0) ? 32'h3f : $random(seed);
			wr(`TOCM_OFS_CMD, {20'h0, r[11:0]});
			repeat (3) @(posedge clk);
			rd(`TOCM_OFS_STATUS, {26'h0, ~(r[5:0] & ~r[11:6])});
		end
		$display("test command done");
		wr(`TOCM_OFS_CMD, 32'hfff);
		wr(`TOCM_OFS_IRQ_STAT, 32'h3ff);
		wr(`TOCM_OFS_IRQ_MASK, 32'h1);
		mon_trip <= 6'h01;
		repeat (3) @(posedge clk);
		chk("irq", 32'h1, 32'(irq));
		wr(`TOCM_OFS_CMD, 32'h8fff);
		// The trip must still stand when the reset edge is seen.
		repeat (2) @(posedge clk);
		mon_trip <= 6'h00;
		repeat (3) @(posedge clk);
		rd(`TOCM_OFS_STATUS, 32'h7e);
		wr(`TOCM_OFS_CMD, 32'hfff);
		wr(`TOCM_OFS_CMD, 32'h8fff);
		repeat (3) @(posedge clk);
		rd(`TOCM_OFS_STATUS, 32'h3f);
		wr(`TOCM_OFS_IRQ_STAT, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq", 32'h0, 32'(irq));
		$display("test latch done");
		wr(`TOCM_OFS_CMD, 32'hfc1);
		for (int p = 0; p < 2; p++) begin
			i_tocm_host.link(p == 0, p == 1);
			repeat (8) @(posedge clk);
			rd(`TOCM_OFS_STATUS, 32'h803e);
			i_tocm_host.link(1'b0, 1'b0);
			repeat (8) @(posedge clk);
			rd(`TOCM_OFS_STATUS, 32'h3f);
		end
		$display("test link done");
		wr(`TOCM_OFS_TIMEOUT, 32'h3);
		wr(`TOCM_OFS_CMD, 32'h7000);
		wt(3'h7, n);
		rd(`TOCM_OFS_STATUS, 32'h703f);
		wt(3'h0, n);
		chk("timeout window", 32'h1, 32'(n >= 12 && n <= 40));
		wr(`TOCM_OFS_CMD, 32'h7000);
		repeat (4) @(posedge clk);
		chk("re-entry", 32'h0, 32'(os_test_active));
		wr(`TOCM_OFS_CMD, 32'h0);
		repeat (3) @(posedge clk);
		chk("test off", 32'h0, 32'(os_test_active));
		wr(`TOCM_OFS_TIMEOUT, 32'h64);
		wr(`TOCM_OFS_CMD, 32'h2000);
		wt(3'h2, n);
		zero_speed <= 3'h2;
		wt(3'h0, n);
		zero_speed <= 3'h0;
		wr(`TOCM_OFS_CMD, 32'h0);
		wr(`TOCM_OFS_CMD, 32'h4000);
		wt(3'h4, n);
		wr(`TOCM_OFS_CMD, 32'h0);
		wt(3'h0, n);
		// An over-speed trip during the test cancels it.
		wr(`TOCM_OFS_CMD, 32'h1000);
		wt(3'h1, n);
		mon_trip <= 6'h01;
		wt(3'h0, n);
		mon_trip <= 6'h00;
		wr(`TOCM_OFS_CMD, 32'h8000);
		repeat (3) @(posedge clk);
		rd(`TOCM_OFS_STATUS, 32'h3f);
		$display("test overspeed done");
		repeat (4) @(posedge clk);
		wrap_up();
	end
endmodule
`default_nettype wire

// File: testbench/tocm_host.sv
// Main processor model: AHB-Lite master and link health pins.
// Assumes a slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
`default_nettype none
module tocm_host (
	// Clock
	input wire logic clk,
	// Bus master side
	output logic hsel,
	output logic [31:0] haddr,
	output tocm_pkg::tocm_htrans_t htrans,
	output logic hwrite,
	output logic [31:0] hwdata,
	input wire logic hready,
	output logic rd_phase,
	// Link health
	output logic comm_lost,
	output logic app_stopped
);
	import tocm_pkg::*;

	// Idle bus at time zero.
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		rd_phase = 1'b0;
		comm_lost = 1'b0;
		app_stopped = 1'b0;
	end

	// One single transfer; released data is inverted so stale values show.
	// A wait that runs out counts a mismatch and ends the run.
	task automatic xfer(input logic w, input logic [31:0] a, d);
		int n;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge clk);
		for (n = 0; n < 64 && hready !== 1'b1; n++) @(posedge clk);
		if (n == 64) begin
			tb_tocm_top.chk("hready address", 32'h1, 32'h0);
			tb_tocm_top.wrap_up();
		end
		htrans <= 2'h0;
		hwdata <= d;
		rd_phase <= !w;
		@(posedge clk);
		for (n = 0; n < 64 && hready !== 1'b1; n++) @(posedge clk);
		if (n == 64) begin
			tb_tocm_top.chk("hready data", 32'h1, 32'h0);
			tb_tocm_top.wrap_up();
		end
		rd_phase <= 1'b0;
		hwdata <= ~d;
	endtask

	// Link pins change just after an edge.
	task automatic link(input logic c, s);
		comm_lost <= c;
		app_stopped <= s;
	endtask
endmodule
`default_nettype wire

// File: testbench/tocm_top_properties.sv
// Port-level checks for the trip output command block.
// Assumes one clock domain and zero-wait bus answers.
`timescale 1ns/1ps
`default_nettype none
module tocm_top_properties #(
	parameter int MS_CYCLES = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire tocm_pkg::tocm_htrans_t htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	// Monitoring and outputs
	input wire logic [5:0] mon_trip,
	input wire logic [2:0] zero_speed,
	input wire logic [5:0] relay_energize,
	input wire logic [2:0] os_test_active,
	input wire logic irq
);
	import tocm_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic rd_q, un_q, st_q;

	// Remember a taken read so its data phase can be judged.
	always_ff @(posedge clk) begin
		rd_q <= rst_n & hsel & hready & htrans[1] & !hwrite;
		un_q <= haddr[7:2] > 6'h04;
		st_q <= haddr[7:2] == 6'h01;
	end

	a_trip_wins: assert property ((mon_trip != 6'h00) |=>
		((relay_energize & $past(mon_trip)) == 6'h00))
		else $error("relay stayed energised on a trip");
	a_trip_cancel: assert property ((mon_trip[0] | zero_speed[0]) |->
		##2 !os_test_active[0]) else $error("group one test not cancelled");
	a_zero_cancel: assert property (zero_speed[1] |->
		##[1:2] !os_test_active[1]) else $error("zero speed kept test on");
	a_status_upper: assert property (rd_q && st_q |->
		hrdata[31:16] == 16'h0000) else $error("status upper bits set");
	a_unmapped_zero: assert property (rd_q && un_q |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!rd_q |-> $stable(hrdata))
		else $error("read data moved without a read");
	a_resp_okay: assert property (hresp == 1'b0) else $error("bad hresp");
	a_ready_high: assert property (hreadyout) else $error("wait inserted");
	c_test_on: cover property ($rose(os_test_active[0]));
	c_irq_off: cover property ($fell(irq));
	c_unmapped: cover property (rd_q && un_q);
endmodule
bind tocm_top tocm_top_properties #(.MS_CYCLES(MS_CYCLES))
	i_tocm_top_properties (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hreadyout, .hrdata, .hresp, .mon_trip, .zero_speed,
	.relay_energize, .os_test_active, .irq);
`default_nettype wire
